// ### src/pmic_regs_pkg.sv
// Constants, register map and field layout of the status and operating-mode register bank.
// Function
// RL1: Top status bit 1 reads 1 while junction temperature is above the lower threshold.
// RL2: Top status bit 0 reads 1 above the upper threshold; bits 7:2 read zero.
// RL3: Address 0x0B shows power-good faults of linear regulators 1 to 8, reset zero.
// RL4: Address 0x0C shows buck fault in bit 7, linear 15 to 9 below.
// RL5: Address 0x0D shows buck-boost power-good fault, over-voltage, over-current; upper bits zero.
// RL6: Address 0x10 holds enable and low-power pairs for linear regulators 4 to 1.
// RL7: Address 0x11 holds enable and low-power pairs for linear regulators 8 to 5.
// RL8: Address 0x12 holds enable and low-power pairs for linear regulators 12 to 9.
// RL9: Address 0x13 holds pairs for linear regulators 15 to 13; bits 7:6 reserved.
// RL10: Address 0x14 bit 3 switches the buck-boost output; bits 7:4 and 2 reserved.
// RL11: Address 0x14 bit 1 enables the buck, bit 0 selects buck low power.
// RL12: Writes to status or reserved addresses are ignored; reserved bits and addresses read zero.
// RL13: Status bits follow the live comparator inputs after a two-stage synchroniser.
package pmic_regs_pkg;

    // Register addresses.
    localparam logic [7:0] TOP_SYSTEM_STATUS_ADDR     = 8'h0A;
    localparam logic [7:0] REGULATOR_STATUS_LOW_ADDR  = 8'h0B;
    localparam logic [7:0] REGULATOR_STATUS_HIGH_ADDR = 8'h0C;
    localparam logic [7:0] BUCK_BOOST_STATUS_ADDR     = 8'h0D;
    localparam logic [7:0] LINEAR_OPMODE_A_ADDR       = 8'h10;
    localparam logic [7:0] LINEAR_OPMODE_B_ADDR       = 8'h11;
    localparam logic [7:0] LINEAR_OPMODE_C_ADDR       = 8'h12;
    localparam logic [7:0] LINEAR_OPMODE_D_ADDR       = 8'h13;
    localparam logic [7:0] SWITCHER_OPMODE_ADDR       = 8'h14;

    // Operating-mode storage.
    localparam int         OPMODE_COUNT         = 5;
    localparam logic [7:0] OPMODE_RESET         = 8'h00;
    localparam logic [7:0] LINEAR_FULL_MASK     = 8'hFF;
    localparam logic [7:0] LINEAR_OPMODE_D_MASK = 8'h3F;
    localparam logic [7:0] SWITCHER_MASK        = 8'h0B;
    localparam int         LINEAR_COUNT         = 15;

    // Field positions.
    localparam int TEMP_LOWER_BIT   = 1;
    localparam int TEMP_UPPER_BIT   = 0;
    localparam int BB_PGOOD_BIT     = 2;
    localparam int BB_OVERVOLT_BIT  = 1;
    localparam int BB_OVERCURR_BIT  = 0;
    localparam int BUCK_PGOOD_BIT   = 7;
    localparam int SW_BUCK_BOOST_OUTPUT_ENABLE_BIT     = 3;
    localparam int SW_BUCK_EN_BIT   = 1;
    localparam int SW_BUCK_LP_BIT   = 0;

    // Layout of the synchronised status vector.
    localparam int ST_BUCK_PGOOD = 15;
    localparam int ST_BB_PGOOD   = 16;
    localparam int ST_BB_OV      = 17;
    localparam int ST_BB_OC      = 18;
    localparam int ST_TEMP_LOW   = 19;
    localparam int ST_TEMP_HIGH  = 20;
    localparam int STATUS_W      = 21;

    // Serial interface.
    localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h2A;
    localparam logic [2:0] BIT_CNT_RESET       = 3'h0;
    localparam logic [7:0] BYTE_RESET          = 8'h00;

    // Bits that software may change in each operating-mode register.
    function automatic logic [7:0] opmode_mask(input logic [2:0] idx);
        logic [7:0] m;
        m = LINEAR_FULL_MASK;
        if (idx == 3'h3) begin
            m = LINEAR_OPMODE_D_MASK;
        end else if (idx == 3'h4) begin
            m = SWITCHER_MASK;
        end
        return m;
    endfunction

endpackage

// ### src/pmic_status_opmode_regs.sv
// Two-wire serial slave with the status and operating-mode register bank.
`timescale 1ns/1ps
`default_nettype none
module pmic_status_opmode_regs
    import pmic_regs_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = DEVICE_ADDR_DEFAULT
) (
    // Clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    rst_n_i,
    // Two-wire serial interface
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    output logic                         sda_o,
    output logic                         sda_oe_o,
    // Live fault and temperature comparators
    input  wire logic                    temp_over_lower_threshold_i,
    input  wire logic                    temp_over_upper_threshold_i,
    input  wire logic [LINEAR_COUNT-1:0] power_good_fault_i,
    input  wire logic                    buck_power_good_fault_i,
    input  wire logic                    buck_boost_power_good_fault_i,
    input  wire logic                    buck_boost_overvoltage_i,
    input  wire logic                    buck_boost_overcurrent_i,
    // Regulator controls
    output logic      [LINEAR_COUNT-1:0] linear_output_enable_o,
    output logic      [LINEAR_COUNT-1:0] linear_low_power_select_o,
    output logic                         buck_output_enable_o,
    output logic                         buck_low_power_select_o,
    output logic                         buck_boost_output_enable_o
);
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ACK_ADDR, S_RX, S_ACK_RX, S_TX, S_ACK_TX, S_WAIT
    } link_state_t;

    link_state_t                  state_r;
    logic                         scl_q_r;
    logic                         sda_q_r;
    logic [2:0]                   bit_cnt_r;
    logic                         byte_done_r;
    logic [7:0]                   shift_r;
    logic [7:0]                   tx_r;
    logic [7:0]                   ptr_r;
    logic                         ptr_phase_r;
    logic                         nack_r;
    logic                         sda_oe_r;
    logic                         wr_en_r;
    logic [7:0]                   wr_addr_r;
    logic [7:0]                   wr_data_r;
    logic [OPMODE_COUNT-1:0][7:0] opmode_r;
    logic [STATUS_W-1:0]          status_raw;
    logic [STATUS_W-1:0]          status_s;
    logic [7:0]                   rd_data;
    logic                         scl_rise;
    logic                         scl_fall;
    logic                         start_cond;
    logic                         stop_cond;

    // The comparators are free-running analog levels, so each passes a synchroniser. [RL13]
    assign status_raw = {temp_over_upper_threshold_i, temp_over_lower_threshold_i,
                         buck_boost_overcurrent_i, buck_boost_overvoltage_i,
                         buck_boost_power_good_fault_i, buck_power_good_fault_i,
                         power_good_fault_i};

    status_sync #(
        .WIDTH (STATUS_W)
    ) u_status_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i (status_raw),
        .sync_o  (status_s)
    );

    // Read data for any address; unmapped addresses and reserved bits read zero.
    function automatic logic [7:0] read_value(input logic [7:0] addr,
                                              input logic [STATUS_W-1:0] st,
                                              input logic [OPMODE_COUNT-1:0][7:0] om);
        logic [7:0] v;
        v = BYTE_RESET;
        unique case (addr)
            TOP_SYSTEM_STATUS_ADDR: begin
                v[TEMP_LOWER_BIT] = st[ST_TEMP_LOW];  // [RL1]
                v[TEMP_UPPER_BIT] = st[ST_TEMP_HIGH]; // [RL2]
            end
            REGULATOR_STATUS_LOW_ADDR: begin
                v = st[7:0]; // [RL3]
            end
            REGULATOR_STATUS_HIGH_ADDR: begin
                v = {st[ST_BUCK_PGOOD], st[14:8]}; // [RL4]
            end
            BUCK_BOOST_STATUS_ADDR: begin
                v[BB_PGOOD_BIT]    = st[ST_BB_PGOOD]; // [RL5]
                v[BB_OVERVOLT_BIT] = st[ST_BB_OV];    // [RL5]
                v[BB_OVERCURR_BIT] = st[ST_BB_OC];    // [RL5]
            end
            LINEAR_OPMODE_A_ADDR: v = om[0];
            LINEAR_OPMODE_B_ADDR: v = om[1];
            LINEAR_OPMODE_C_ADDR: v = om[2];
            LINEAR_OPMODE_D_ADDR: v = om[3];
            SWITCHER_OPMODE_ADDR: v = om[4];
            default:              v = BYTE_RESET; // [RL12]
        endcase
        return v;
    endfunction

    assign rd_data = read_value(ptr_r, status_s, opmode_r);

    // Bus conditions from the previous sample of both lines.
    assign scl_rise   = scl_i & ~scl_q_r;
    assign scl_fall   = ~scl_i & scl_q_r;
    assign start_cond = scl_i & scl_q_r & sda_q_r & ~sda_i;
    assign stop_cond  = scl_i & scl_q_r & ~sda_q_r & sda_i;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
        end
    end

    // Protocol engine: the slave changes its data line only after a clock fall.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r     <= S_IDLE;
            bit_cnt_r   <= BIT_CNT_RESET;
            byte_done_r <= 1'b0;
            shift_r     <= BYTE_RESET;
            tx_r        <= BYTE_RESET;
            ptr_r       <= BYTE_RESET;
            ptr_phase_r <= 1'b0;
            nack_r      <= 1'b0;
            sda_oe_r    <= 1'b0;
            wr_en_r     <= 1'b0;
            wr_addr_r   <= BYTE_RESET;
            wr_data_r   <= BYTE_RESET;
        end else begin
            wr_en_r <= 1'b0;
            if (start_cond) begin
                state_r     <= S_ADDR;
                bit_cnt_r   <= BIT_CNT_RESET;
                byte_done_r <= 1'b0;
                sda_oe_r    <= 1'b0;
            end else if (stop_cond) begin
                state_r  <= S_IDLE;
                sda_oe_r <= 1'b0;
            end else begin
                unique case (state_r)
                    S_IDLE, S_WAIT: begin
                        sda_oe_r <= 1'b0;
                    end
                    S_ADDR, S_RX: begin
                        if (scl_rise) begin
                            shift_r     <= {shift_r[6:0], sda_i};
                            bit_cnt_r   <= bit_cnt_r + 3'h1;
                            byte_done_r <= (bit_cnt_r == 3'h7);
                        end else if (scl_fall && byte_done_r) begin
                            byte_done_r <= 1'b0;
                            if (state_r == S_ADDR) begin
                                if (shift_r[7:1] == DEVICE_ADDR) begin
                                    sda_oe_r <= 1'b1;
                                    state_r  <= S_ACK_ADDR;
                                end else begin
                                    state_r <= S_WAIT;
                                end
                            end else begin
                                sda_oe_r <= 1'b1;
                                state_r  <= S_ACK_RX;
                                if (ptr_phase_r) begin
                                    ptr_r <= shift_r;
                                end else begin
                                    wr_en_r   <= 1'b1;
                                    wr_addr_r <= ptr_r;
                                    wr_data_r <= shift_r;
                                    ptr_r     <= ptr_r + 8'h01;
                                end
                            end
                        end
                    end
                    S_ACK_ADDR: begin
                        if (scl_fall) begin
                            bit_cnt_r <= BIT_CNT_RESET;
                            if (shift_r[0]) begin
                                tx_r     <= rd_data;
                                sda_oe_r <= ~rd_data[7];
                                ptr_r    <= ptr_r + 8'h01;
                                state_r  <= S_TX;
                            end else begin
                                sda_oe_r    <= 1'b0;
                                ptr_phase_r <= 1'b1;
                                state_r     <= S_RX;
                            end
                        end
                    end
                    S_ACK_RX: begin
                        if (scl_fall) begin
                            sda_oe_r    <= 1'b0;
                            ptr_phase_r <= 1'b0;
                            bit_cnt_r   <= BIT_CNT_RESET;
                            state_r     <= S_RX;
                        end
                    end
                    S_TX: begin
                        if (scl_rise) begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_r == BIT_CNT_RESET) begin
                                sda_oe_r <= 1'b0;
                                state_r  <= S_ACK_TX;
                            end else begin
                                sda_oe_r <= ~tx_r[~bit_cnt_r];
                            end
                        end
                    end
                    S_ACK_TX: begin
                        if (scl_rise) begin
                            nack_r <= sda_i;
                        end else if (scl_fall) begin
                            if (!nack_r) begin
                                tx_r      <= rd_data;
                                sda_oe_r  <= ~rd_data[7];
                                ptr_r     <= ptr_r + 8'h01;
                                bit_cnt_r <= BIT_CNT_RESET;
                                state_r   <= S_TX;
                            end else begin
                                state_r <= S_WAIT;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Operating-mode registers; status and reserved addresses drop the write. [RL12]
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < OPMODE_COUNT; i++) begin
                opmode_r[i] <= OPMODE_RESET; // [RL6] [RL7] [RL8] [RL9] [RL10] [RL11]
            end
        end else if (wr_en_r && wr_addr_r >= LINEAR_OPMODE_A_ADDR
                     && wr_addr_r <= SWITCHER_OPMODE_ADDR) begin
            // Reserved bits are masked so they always read back zero. [RL9] [RL10] [RL12]
            opmode_r[3'(wr_addr_r - LINEAR_OPMODE_A_ADDR)] <=
                wr_data_r & opmode_mask(3'(wr_addr_r - LINEAR_OPMODE_A_ADDR));
        end
    end

    // Each linear regulator owns a pair: enable above, low-power select below.
    always_comb begin
        for (int n = 0; n < LINEAR_COUNT; n++) begin
            linear_output_enable_o[n]    = opmode_r[n / 4][(n % 4) * 2 + 1]; // [RL6] [RL7]
            linear_low_power_select_o[n] = opmode_r[n / 4][(n % 4) * 2];     // [RL8] [RL9]
        end
    end

    assign buck_boost_output_enable_o = opmode_r[4][SW_BUCK_BOOST_OUTPUT_ENABLE_BIT];   // [RL10]
    assign buck_output_enable_o       = opmode_r[4][SW_BUCK_EN_BIT]; // [RL11]
    assign buck_low_power_select_o    = opmode_r[4][SW_BUCK_LP_BIT]; // [RL11]

    // Open-drain line: only ever pulled low, the enable carries the data.
    assign sda_o    = 1'b0;
    assign sda_oe_o = sda_oe_r;
endmodule
`default_nettype wire

// ### src/status_sync.sv
// Two-stage synchroniser for the live status comparator levels.
`timescale 1ns/1ps
`default_nettype none
module status_sync
    import pmic_regs_pkg::*;
#(
    parameter int WIDTH = STATUS_W
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule
`default_nettype wire

// ### tb/i2c_host_model.sv
// Behavioural two-wire bus host issuing register writes and pointer-then-read transfers.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    // Clock and resolved data line
    input  wire logic mclk_i,
    input  wire logic sda_i,
    // Host drive; a 1 on the data drive releases the line to its pull-up
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // A six-cycle low phase keeps every data change well clear of both clock edges.
    task automatic bit_io(input logic b, output logic r);
        scl_o = 1'b0;
        cyc(3);
        sda_o = b;
        cyc(3);
        scl_o = 1'b1;
        cyc(2);
        r = sda_i;
        cyc(2);
    endtask

    // Start is (1,0), stop is (0,1): the data line moves while the clock is high.
    task automatic edge_seq(input logic a, input logic b);
        scl_o = 1'b0;
        cyc(3);
        sda_o = a;
        cyc(3);
        scl_o = 1'b1;
        cyc(4);
        sda_o = b;
        cyc(4);
    endtask

    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                        input logic rd, output logic [7:0] q, output logic ok);
        logic a0;
        logic a1;
        edge_seq(1'b1, 1'b0);
        byte_io({dev, 1'b0}, q, a0);
        byte_io(ptr, q, a1);
        ok = a0 & a1;
        if (rd) begin
            edge_seq(1'b1, 1'b0);
            byte_io({dev, 1'b1}, q, a0);
            ok = ok & a0;
            byte_io(8'hFF, q, a1);
        end else begin
            byte_io(d, q, a0);
            ok = ok & a0;
        end
        edge_seq(1'b0, 1'b1);
    endtask
endmodule
`default_nettype wire

// ### tb/pmic_regs_sva.sv
// Concurrent checks on the serial line and the regulator control outputs of the register bank.
`timescale 1ns/1ps
`default_nettype none
module pmic_regs_sva
    import pmic_regs_pkg::*;
(
    // Clock and reset
    input wire logic                    mclk_i,
    input wire logic                    rst_n_i,
    // Serial line
    input wire logic                    scl_i,
    input wire logic                    sda_o,
    input wire logic                    sda_oe_o,
    // Regulator controls
    input wire logic [LINEAR_COUNT-1:0] linear_output_enable_o,
    input wire logic [LINEAR_COUNT-1:0] linear_low_power_select_o,
    input wire logic                    buck_output_enable_o,
    input wire logic                    buck_low_power_select_o,
    input wire logic                    buck_boost_output_enable_o
);
    logic [1:0]      up_r;
    wire logic [2:0] sw = {buck_boost_output_enable_o, buck_output_enable_o,
                           buck_low_power_select_o};

    // The first edges after a reset still compare against values from before it, so skip them.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    lin_en_reset_a: assert property ($rose(rst_n_i) |-> linear_output_enable_o == '0)
        else $error("Linear enables not clear after reset.");
    lin_lp_reset_a: assert property ($rose(rst_n_i) |-> linear_low_power_select_o == '0)
        else $error("Linear low-power selects not clear after reset.");
    sw_reset_a: assert property ($rose(rst_n_i) |-> sw == 3'h0)
        else $error("Switcher controls not clear after reset.");
    lin_scl_low_a: assert property (up_r == 2'h3 && $changed({linear_output_enable_o,
        linear_low_power_select_o}) |-> !$past(scl_i) && !$past(scl_i, 2))
        else $error("Linear controls changed outside a serial clock low phase.");
    sw_scl_low_a: assert property (up_r == 2'h3 && $changed(sw) |-> !$past(scl_i, 1)
        && !$past(scl_i, 2)) else $error("Switcher controls changed outside a clock low phase.");
    oe_scl_low_a: assert property (up_r == 2'h3 && $changed(sda_oe_o)
        |-> !scl_i && !$past(scl_i))
        else $error("Data drive changed while serial clock high.");
    oe_high_stable_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("Data drive moved during a clock high phase.");
    sda_pull_low_a: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("Data line driven high.");
    oe_reset_a: assert property ($rose(rst_n_i) |-> !sda_oe_o)
        else $error("Data line driven right after reset.");

    cover property ($changed(linear_output_enable_o));
    cover property ($rose(sda_oe_o));
    cover property ($rose(buck_boost_output_enable_o));
endmodule
`default_nettype wire

// ### tb/pmic_status_opmode_regs_test.sv
// Self-checking bench for the status and operating-mode register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("ERROR %0t: got %h expected %h", $time, g, e); \
    end \
end
module pmic_status_opmode_regs_test
    import pmic_regs_pkg::*;
;
    logic                    mclk_i, rst_n_i, scl, sda_host, sda_oe, sda_out;
    logic                    t_low, t_high, buck_pg, bb_pg, bb_ov, bb_oc, buck_en, buck_lp, buck_boost_output_enable;
    logic [LINEAR_COUNT-1:0] pgf, lin_en, lin_lp;
    logic [7:0]              om [5];
    int                      n_errors, check_count, cycles;
    wire logic               sda_line = sda_host & ~(sda_oe & ~sda_out);

    pmic_status_opmode_regs dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_out), .sda_oe_o(sda_oe), .temp_over_lower_threshold_i(t_low),
        .temp_over_upper_threshold_i(t_high), .power_good_fault_i(pgf),
        .buck_power_good_fault_i(buck_pg), .buck_boost_power_good_fault_i(bb_pg),
        .buck_boost_overvoltage_i(bb_ov), .buck_boost_overcurrent_i(bb_oc),
        .linear_output_enable_o(lin_en), .linear_low_power_select_o(lin_lp),
        .buck_output_enable_o(buck_en), .buck_low_power_select_o(buck_lp),
        .buck_boost_output_enable_o(buck_boost_output_enable));
    i2c_host_model host (.mclk_i(mclk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(sda_host));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_n_i = 1'b0;
        repeat (12) @(posedge mclk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                      input logic e_ok);
        logic [7:0] q;
        logic       ok;
        host.xfer(dev, a, d, 1'b0, q, ok);
        `CHK(ok, e_ok)
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic       ok;
        host.xfer(DEVICE_ADDR_DEFAULT, a, 8'h00, 1'b1, q, ok);
        `CHK(ok, 1'b1)
        `CHK(q, e)
    endtask

    // Enable is the upper bit of each pair, low power the lower one.
    task automatic chk_out();
        logic [14:0] en;
        logic [14:0] lp;
        for (int i = 0; i < 15; i++) begin
            en[i] = om[i / 4][(i % 4) * 2 + 1];
            lp[i] = om[i / 4][(i % 4) * 2];
        end
        `CHK(lin_en, en)
        `CHK(lin_lp, lp)
        `CHK({buck_boost_output_enable, buck_en, buck_lp}, {om[4][3], om[4][1], om[4][0]})
    endtask

    task automatic t_reset();
        logic [7:0] a;
        for (int i = 0; i < 5; i++) begin
            om[i] = 8'h00;
        end
        chk_out();
        for (int i = 0; i < 9; i++) begin
            a = (i < 4) ? 8'h0A + 8'(i) : 8'h0C + 8'(i);
            rd(a, 8'h00);
        end
        $display("reset test done");
    endtask

    task automatic t_opmode();
        logic [7:0] wv [5] = '{8'h96, 8'h5A, 8'hC3, 8'hED, 8'hFF};
        logic [7:0] mk [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h0B};
        for (int i = 0; i < 5; i++) begin
            wr(DEVICE_ADDR_DEFAULT, 8'h10 + 8'(i), wv[i], 1'b1);
            om[i] = wv[i] & mk[i];
            chk_out();
        end
        for (int i = 0; i < 5; i++) begin
            rd(8'h10 + 8'(i), om[i]);
        end
        wr(DEVICE_ADDR_DEFAULT, 8'h14, 8'h01, 1'b1);
        om[4] = 8'h01;
        chk_out();
        $display("opmode test done");
    endtask

    // Two input sets differing in the temperature and buck-boost bits and in the linear faults the first sets show reads follow live levels, not latched ones.
    task automatic t_status();
        {t_low, t_high, buck_pg, bb_pg, bb_ov, bb_oc, pgf} = {6'h2D, 15'h4A31};
        repeat (4) @(posedge mclk_i);
        #1;
        rd(8'h0A, 8'h02);
        rd(8'h0B, 8'h31);
        rd(8'h0C, 8'hCA);
        rd(8'h0D, 8'h05);
        {t_low, t_high, buck_pg, bb_pg, bb_ov, bb_oc, pgf} = {6'h1A, 15'h0000};
        rd(8'h0A, 8'h01);
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'h80);
        rd(8'h0D, 8'h02);
        $display("status test done");
    endtask

    task automatic t_refuse();
        wr(DEVICE_ADDR_DEFAULT, 8'h0B, 8'hFF, 1'b1);
        wr(DEVICE_ADDR_DEFAULT, 8'h0E, 8'hFF, 1'b1);
        wr(DEVICE_ADDR_DEFAULT, 8'h15, 8'hFF, 1'b1);
        wr(DEVICE_ADDR_DEFAULT ^ 7'h01, 8'h10, 8'hFF, 1'b0);
        chk_out();
        rd(8'h0B, 8'h00);
        rd(8'h0E, 8'h00);
        rd(8'h15, 8'h00);
        $display("refusal test done");
    endtask

    // One frame writes two registers; a read in which the host acknowledges the first byte and not the second then fetches both.
    task automatic t_burst();
        logic [7:0] q;
        logic [3:0] ack;
        logic       r;
        om[0] = 8'hA5;
        om[1] = 8'h3C;
        host.edge_seq(1'b1, 1'b0);
        host.byte_io({DEVICE_ADDR_DEFAULT, 1'b0}, q, ack[0]);
        host.byte_io(8'h10, q, ack[1]);
        host.byte_io(om[0], q, ack[2]);
        host.byte_io(om[1], q, ack[3]);
        host.edge_seq(1'b0, 1'b1);
        `CHK(ack, 4'hF)
        chk_out();
        host.edge_seq(1'b1, 1'b0);
        host.byte_io({DEVICE_ADDR_DEFAULT, 1'b0}, q, ack[0]);
        host.byte_io(8'h10, q, ack[1]);
        host.edge_seq(1'b1, 1'b0);
        host.byte_io({DEVICE_ADDR_DEFAULT, 1'b1}, q, ack[2]);
        for (int i = 7; i >= 0; i--) begin
            host.bit_io(1'b1, r);
            q[i] = r;
        end
        host.bit_io(1'b0, r);
        `CHK(q, om[0])
        host.byte_io(8'hFF, q, ack[3]);
        host.edge_seq(1'b0, 1'b1);
        `CHK(q, om[1])
        `CHK(ack, 4'h7)
        $display("burst test done");
    endtask

    initial begin
        {rst_n_i, t_low, t_high, buck_pg, bb_pg, bb_ov, bb_oc, pgf} = '0;
        do_reset();
        t_reset();
        t_opmode();
        do_reset();
        t_reset();
        t_status();
        t_refuse();
        t_burst();
        end_of_test();
    end
endmodule

bind pmic_status_opmode_regs pmic_regs_sva u_sva (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .linear_output_enable_o(linear_output_enable_o),
    .linear_low_power_select_o(linear_low_power_select_o),
    .buck_output_enable_o(buck_output_enable_o),
    .buck_low_power_select_o(buck_low_power_select_o),
    .buck_boost_output_enable_o(buck_boost_output_enable_o));
`default_nettype wire
